// [smbiw_asserts.sv]
/*
 checker of the link wires between host end and device end.
 assumes it watches the first interface, on the system clock.
*/
`timescale 1ns/1ps
`default_nettype none
module smbiw_asserts
    import smbiw_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // link wires
    input wire logic scl_oe_n_host,
    input wire logic sda_oe_n_host,
    input wire logic sda_oe_n_dev,
    input wire logic scl,
    input wire logic sda
);
    // ------------------------------------------------------------
    // frame tracking
    // ------------------------------------------------------------
    logic scl_q;
    logic sda_q;
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic [7:0] byte_q;
    logic [7:0] byte_d;
    logic [7:0] sh_q;
    logic [7:0] sh_d;
    logic [7:0] x_q;
    logic [7:0] x_d;
    always_comb begin
        cnt_d = cnt_q;
        byte_d = byte_q;
        sh_d = sh_q;
        x_d = x_q;
        if (scl && scl_q && (sda != sda_q)) begin
            cnt_d = 4'h0;
            byte_d = 8'h00;
        end else if (scl && !scl_q) begin
            cnt_d = (cnt_q == 4'h9) ? 4'h1 : cnt_q + 4'h1;
            if (cnt_q == 4'h9) byte_d = byte_q + 8'h01;
            if (cnt_q != 4'h8) sh_d = {sh_q[6:0], sda};
            if (cnt_q == 4'h8 && byte_q == 8'h02) x_d = sh_q;
        end
    end
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            cnt_q <= 4'h0;
            byte_q <= 8'h00;
            sh_q <= 8'h00;
            x_q <= 8'h00;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
            cnt_q <= cnt_d;
            byte_q <= byte_d;
            sh_q <= sh_d;
            x_q <= x_d;
        end
    end
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    a_addr_ack: assert property (
        $rose(scl) && cnt_q == 4'h8 && byte_q == 8'h00 && sh_q == SMBIW_WR_ADDR |-> !sda_oe_n_dev)
        else $error("address byte not acknowledged");
    a_index_ack: assert property (
        $rose(scl) && cnt_q == 4'h8 && byte_q == 8'h01 |-> !sda_oe_n_dev)
        else $error("index byte not acknowledged");
    a_count_ack: assert property (
        $rose(scl) && cnt_q == 4'h8 && byte_q == 8'h02 |-> !sda_oe_n_dev)
        else $error("count byte not acknowledged");
    a_data_ack: assert property (
        $rose(scl) && cnt_q == 4'h8 && byte_q >= 8'h03
        && {1'b0, byte_q} < {1'b0, x_q} + 9'h003 |-> !sda_oe_n_dev)
        else $error("data byte not acknowledged");
    a_bits_released: assert property (
        scl && scl_q && cnt_q != 4'h9 |-> sda_oe_n_dev)
        else $error("device drives sda outside ack slot");
    a_ack_release: assert property (
        $fell(scl) && cnt_q == 4'h9 |-> ##[1:8] sda_oe_n_dev)
        else $error("ack not released after ninth bit");
    a_ack_launch: assert property (
        $fell(scl) && cnt_q == 4'h8 && (byte_q == 8'h01 || byte_q == 8'h02)
        |-> ##[1:8] (!sda_oe_n_dev [*8]))
        else $error("ack not driven after eighth bit");
endmodule
`default_nettype wire

// [smbiw_dev.sv]
/*
 device end: slave receiver of the index block write, with its register file.
 assumes scl and sda come from the pins, outside the clock domain.
*/
// How it works
// - host opens each write with start
// - address D2 is acknowledged by device
// - index byte acknowledged, sets first location
// - byte count acknowledged after index
// - data stored at N up to N+X-1
// - every data byte within the count acknowledged separately
// - host ends block with stop
`timescale 1ns/1ps
`default_nettype none
module smbiw_dev
    import smbiw_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // link
    smbiw_if.dev link,
    // user side
    input wire logic [7:0] rd_index,
    output logic [7:0] rd_data,
    output logic wr_pulse,
    output logic [7:0] wr_index,
    output logic [7:0] wr_data,
    output logic busy
);
    typedef enum logic [2:0] {
        SMBIW_IDLE = 3'b000,
        SMBIW_ADDR = 3'b001,
        SMBIW_INDEX = 3'b010,
        SMBIW_COUNT = 3'b011,
        SMBIW_DATA = 3'b100,
        SMBIW_IGNORE = 3'b101
    } smbiw_dst_e;

    // ------------------------------------------------------------
    // pin synchronisers and edge detection
    // ------------------------------------------------------------
    logic [1:0] scl_s_q, sda_s_q;
    logic scl_p_q, sda_p_q;
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            scl_s_q <= 2'h3;
            sda_s_q <= 2'h3;
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_s_q <= {scl_s_q[0], link.scl};
            sda_s_q <= {sda_s_q[0], link.sda};
            scl_p_q <= scl_s_q[1];
            sda_p_q <= sda_s_q[1];
        end
    end
    logic scl_r, scl_f, start_c, stop_c;
    assign scl_r = scl_s_q[1] & ~scl_p_q;
    assign scl_f = ~scl_s_q[1] & scl_p_q;
    assign start_c = scl_s_q[1] & scl_p_q & sda_p_q & ~sda_s_q[1];
    assign stop_c = scl_s_q[1] & scl_p_q & ~sda_p_q & sda_s_q[1];

    // ------------------------------------------------------------
    // frame state
    // ------------------------------------------------------------
    smbiw_dst_e st_q, st_d;
    logic [3:0] bit_q, bit_d;
    logic [7:0] sh_q, sh_d, idx_q, idx_d, cnt_q, cnt_d;
    logic ack_q, ack_d, sda_oe_n_q, sda_oe_n_d;
    logic wr_pulse_d;
    logic [7:0] wr_index_d, wr_data_d;
    logic [7:0] regs_q [SMBIW_NUM_REGS];

    always_comb begin
        st_d = st_q;
        bit_d = bit_q;
        sh_d = sh_q;
        idx_d = idx_q;
        cnt_d = cnt_q;
        ack_d = ack_q;
        sda_oe_n_d = sda_oe_n_q;
        wr_pulse_d = 1'b0;
        wr_index_d = wr_index;
        wr_data_d = wr_data;
        if (start_c) begin
            st_d = SMBIW_ADDR;
            bit_d = 4'h0;
            ack_d = 1'b0;
            sda_oe_n_d = 1'b1;
        end else if (stop_c) begin
            st_d = SMBIW_IDLE;
            sda_oe_n_d = 1'b1;
        end else if (st_q != SMBIW_IDLE && st_q != SMBIW_IGNORE) begin
            if (scl_r && !ack_q) begin
                sh_d = {sh_q[6:0], sda_s_q[1]};
                bit_d = bit_q + 4'h1;
            end
            if (scl_f) begin
                if (ack_q) begin
                    sda_oe_n_d = 1'b1;
                    ack_d = 1'b0;
                    bit_d = 4'h0;
                end else if (bit_q == 4'h8) begin
                    ack_d = 1'b1;
                    sda_oe_n_d = 1'b0;
                    unique case (st_q)
                        SMBIW_ADDR: begin
                            if (sh_q == SMBIW_WR_ADDR) begin
                                st_d = SMBIW_INDEX;
                            end else begin
                                st_d = SMBIW_IGNORE;
                                ack_d = 1'b0;
                                sda_oe_n_d = 1'b1;
                            end
                        end
                        SMBIW_INDEX: begin
                            idx_d = sh_q;
                            st_d = SMBIW_COUNT;
                        end
                        SMBIW_COUNT: begin
                            cnt_d = sh_q;
                            st_d = SMBIW_DATA;
                        end
                        SMBIW_DATA: begin
                            if (cnt_q != 8'h00) begin
                                wr_pulse_d = 1'b1;
                                wr_index_d = idx_q;
                                wr_data_d = sh_q;
                                idx_d = idx_q + 8'h01;
                                cnt_d = cnt_q - 8'h01;
                            end else begin
                                ack_d = 1'b0; // surplus bytes refused
                                sda_oe_n_d = 1'b1;
                                st_d = SMBIW_IGNORE;
                            end
                            // one ack per byte above
                        end
                        default: begin
                            st_d = SMBIW_IGNORE;
                        end
                    endcase
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= SMBIW_IDLE;
            bit_q <= 4'h0;
            sh_q <= 8'h00;
            idx_q <= 8'h00;
            cnt_q <= 8'h00;
            ack_q <= 1'b0;
            sda_oe_n_q <= 1'b1;
            wr_pulse <= 1'b0;
            wr_index <= 8'h00;
            wr_data <= 8'h00;
        end else begin
            st_q <= st_d;
            bit_q <= bit_d;
            sh_q <= sh_d;
            idx_q <= idx_d;
            cnt_q <= cnt_d;
            ack_q <= ack_d;
            sda_oe_n_q <= sda_oe_n_d;
            wr_pulse <= wr_pulse_d;
            wr_index <= wr_index_d;
            wr_data <= wr_data_d;
        end
    end

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < SMBIW_NUM_REGS; i++) begin
                regs_q[i] <= SMBIW_REG_RESET;
            end
            rd_data <= SMBIW_REG_RESET;
            busy <= 1'b0;
        end else begin
            if (wr_pulse_d) begin
                regs_q[wr_index_d] <= wr_data_d;
            end
            rd_data <= regs_q[rd_index];
            busy <= (st_d != SMBIW_IDLE) && (st_d != SMBIW_IGNORE);
        end
    end
    assign link.sda_oe_n_dev = sda_oe_n_q;
endmodule
`default_nettype wire

// [smbiw_host.sv]
/*
 host end: issues one index block write per request, bytes from a user port.
 assumes a device end joined over the same interface, same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module smbiw_host
    import smbiw_pkg::*;
#(
    parameter logic [9:0] QTR_LAST = SMBIW_QTR_LAST
)
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // link
    smbiw_if.host link,
    // user side
    input wire logic req,
    input wire logic [7:0] index,
    input wire logic [7:0] count,
    input wire logic [7:0] data_in,
    output logic data_take,
    output logic busy,
    output logic done,
    output logic nack_err
);
    typedef enum logic [2:0] {
        SMBIW_H_IDLE = 3'b000,
        SMBIW_H_START = 3'b001,
        SMBIW_H_BYTE = 3'b010,
        SMBIW_H_STOP = 3'b011,
        SMBIW_H_DONE = 3'b100
    } smbiw_hst_e;

    // ------------------------------------------------------------
    // sda synchroniser
    // ------------------------------------------------------------
    logic [1:0] sda_s_q;
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            sda_s_q <= 2'h3;
        end else begin
            sda_s_q <= {sda_s_q[0], link.sda};
        end
    end

    // ------------------------------------------------------------
    // sequencer: one bit is four quarter periods
    // ------------------------------------------------------------
    smbiw_hst_e st_q, st_d;
    logic [9:0] tq_q, tq_d;
    logic [1:0] ph_q, ph_d;
    logic [3:0] bit_q, bit_d;
    logic [1:0] fld_q, fld_d;
    logic [7:0] sh_q, sh_d, left_q, left_d;
    logic scl_q, scl_d, sda_q, sda_d;
    logic take_d, done_d, nack_q, nack_d;
    logic tick;
    assign tick = (tq_q == QTR_LAST);

    always_comb begin
        st_d = st_q;
        tq_d = tick ? 10'h000 : tq_q + 10'h001;
        ph_d = ph_q;
        bit_d = bit_q;
        fld_d = fld_q;
        sh_d = sh_q;
        left_d = left_q;
        scl_d = scl_q;
        sda_d = sda_q;
        take_d = 1'b0;
        done_d = 1'b0;
        nack_d = nack_q;
        unique case (st_q)
            SMBIW_H_IDLE: begin
                tq_d = 10'h000;
                if (req) begin
                    st_d = SMBIW_H_START;
                    ph_d = 2'h0;
                    nack_d = 1'b0;
                    left_d = count;
                end
            end
            SMBIW_H_START: begin
                if (tick) begin
                    ph_d = ph_q + 2'h1;
                    if (ph_q == 2'h0) begin
                        sda_d = 1'b0;
                    end else if (ph_q == 2'h1) begin
                        scl_d = 1'b0;
                        st_d = SMBIW_H_BYTE;
                        ph_d = 2'h0;
                        bit_d = 4'h0;
                        fld_d = 2'h0;
                        sh_d = SMBIW_WR_ADDR;
                    end
                end
            end
            SMBIW_H_BYTE: begin
                if (tick) begin
                    ph_d = ph_q + 2'h1;
                    unique case (ph_q)
                        2'h0: sda_d = (bit_q == 4'h8) ? 1'b1 : sh_q[7];
                        2'h1: scl_d = 1'b1;
                        2'h2: begin
                            if (bit_q == 4'h8 && sda_s_q[1]) begin
                                nack_d = 1'b1;
                            end
                        end
                        2'h3: begin
                            scl_d = 1'b0;
                            sh_d = {sh_q[6:0], 1'b0};
                            bit_d = bit_q + 4'h1;
                            if (bit_q == 4'h8) begin
                                bit_d = 4'h0;
                                fld_d = (fld_q == 2'h3) ? 2'h3 : fld_q + 2'h1;
                                if (nack_q || (fld_q >= 2'h2 && left_q == 8'h00)) begin
                                    st_d = SMBIW_H_STOP;
                                end else if (fld_q == 2'h0) begin
                                    sh_d = index;
                                end else if (fld_q == 2'h1) begin
                                    sh_d = count;
                                end else begin
                                    sh_d = data_in;
                                    take_d = 1'b1;
                                    left_d = left_q - 8'h01;
                                end
                            end
                        end
                    endcase
                end
            end
            SMBIW_H_STOP: begin
                if (tick) begin
                    ph_d = ph_q + 2'h1;
                    if (ph_q == 2'h0) begin
                        sda_d = 1'b0;
                    end else if (ph_q == 2'h1) begin
                        scl_d = 1'b1;
                    end else if (ph_q == 2'h2) begin
                        sda_d = 1'b1;
                        st_d = SMBIW_H_DONE;
                    end
                end
            end
            SMBIW_H_DONE: begin
                if (tick) begin
                    done_d = 1'b1;
                    st_d = SMBIW_H_IDLE;
                end
            end
            default: begin
                st_d = SMBIW_H_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= SMBIW_H_IDLE;
            tq_q <= 10'h000;
            ph_q <= 2'h0;
            bit_q <= 4'h0;
            fld_q <= 2'h0;
            sh_q <= 8'h00;
            left_q <= 8'h00;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            nack_q <= 1'b0;
            data_take <= 1'b0;
            done <= 1'b0;
            busy <= 1'b0;
            nack_err <= 1'b0;
        end else begin
            st_q <= st_d;
            tq_q <= tq_d;
            ph_q <= ph_d;
            bit_q <= bit_d;
            fld_q <= fld_d;
            sh_q <= sh_d;
            left_q <= left_d;
            scl_q <= scl_d;
            sda_q <= sda_d;
            nack_q <= nack_d;
            data_take <= take_d;
            done <= done_d;
            busy <= (st_d != SMBIW_H_IDLE);
            nack_err <= done_d ? nack_q : nack_err;
        end
    end
    assign link.scl_oe_n_host = scl_q;
    assign link.sda_oe_n_host = sda_q;
endmodule
`default_nettype wire

// [smbiw_if.sv]
/*
 two-wire serial link between the host and the device.
 resolves sda as the wired-and of the two ends and drives scl from the host
 enable alone, each wire low where an output enable is low.
*/
`timescale 1ns/1ps
`default_nettype none
interface smbiw_if;
    logic scl_oe_n_host;
    logic sda_oe_n_host;
    logic sda_oe_n_dev;
    logic scl;
    logic sda;
    assign scl = scl_oe_n_host;
    assign sda = sda_oe_n_host & sda_oe_n_dev;
    modport host (output scl_oe_n_host, output sda_oe_n_host, input scl, input sda);
    modport dev (output sda_oe_n_dev, input scl, input sda);
endinterface
`default_nettype wire

// [smbiw_pkg.sv]
/*
 package of the index block write serial port: bus addresses,
 register file size and bit timing of the host end.
 assumes a single 250 MHz system clock on both ends.
*/
`default_nettype none
package smbiw_pkg;
    // ------------------------------------------------------------
    // addresses
    // ------------------------------------------------------------
    localparam logic [7:0] SMBIW_WR_ADDR = 8'hD2;
    localparam logic [7:0] SMBIW_RD_ADDR = 8'hD3;
    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    localparam int SMBIW_NUM_REGS = 256;
    localparam logic [7:0] SMBIW_REG_RESET = 8'h00;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int SMBIW_CLK_MHZ = 250;
    localparam int SMBIW_QTR_NS = 2500;
    localparam int SMBIW_QTR_CYC = (SMBIW_QTR_NS * SMBIW_CLK_MHZ) / 1000;
    localparam logic [9:0] SMBIW_QTR_LAST = 10'(SMBIW_QTR_CYC - 1);
endpackage
`default_nettype wire

// [smbiw_tb.sv]
/*
 testbench: host end and device on one link, bench bit-bang on a second.
 assumes the design files and the checker are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
module smbiw_tb
    import smbiw_pkg::*;
;
    logic sys_clk;
    logic resetn;
    logic req = 1'b0;
    logic [7:0] index = 8'h00;
    logic [7:0] count = 8'h00;
    logic [7:0] data_in = 8'h00;
    logic [7:0] rd_idx = 8'h00;
    logic data_take, hbusy, done, nack_err, wp1, wp2, db1, db2;
    logic [7:0] rd1, rd2, wi1, wd1;
    logic [7:0] n1 = 8'h00;
    logic [7:0] n2 = 8'h00;
    logic [7:0] nt = 8'h00;
    logic saw_b = 1'b0;
    int error_cnt = 0;
    int check_count = 0;
    int cyc = 0;
    smbiw_if link1 ();
    smbiw_if link2 ();
    // short quarter period keeps the run brief
    smbiw_host #(.QTR_LAST(10'h00F)) smbiw_host_i (.sys_clk(sys_clk), .resetn(resetn),
        .link(link1), .req(req), .index(index), .count(count), .data_in(data_in),
        .data_take(data_take), .busy(hbusy), .done(done), .nack_err(nack_err));
    smbiw_dev smbiw_dev_i (.sys_clk(sys_clk), .resetn(resetn), .link(link1),
        .rd_index(rd_idx), .rd_data(rd1), .wr_pulse(wp1), .wr_index(wi1), .wr_data(wd1),
        .busy(db1));
    smbiw_dev smbiw_dev2_i (.sys_clk(sys_clk), .resetn(resetn), .link(link2),
        .rd_index(rd_idx), .rd_data(rd2), .wr_pulse(wp2), .wr_index(), .wr_data(),
        .busy(db2));
    smbiw_asserts smbiw_asserts_i (.sys_clk(sys_clk), .resetn(resetn),
        .scl_oe_n_host(link1.scl_oe_n_host), .sda_oe_n_host(link1.sda_oe_n_host),
        .sda_oe_n_dev(link1.sda_oe_n_dev), .scl(link1.scl), .sda(link1.sda));
    // ------------------------------------------------------------
    // clock, monitors, timeout
    // ------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        if (wp1 === 1'b1) n1 <= n1 + 8'h01;
        if (wp2 === 1'b1) n2 <= n2 + 8'h01;
        if (data_take === 1'b1) nt <= nt + 8'h01;
        if (db1 === 1'b1) saw_b <= 1'b1;
        cyc++;
        if (cyc == 40000) begin
            error_cnt++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        if (error_cnt == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rchk(input bit b, input logic [7:0] i, input logic [7:0] e);
        rd_idx <= i;
        repeat (2) @(posedge sys_clk);
        chk("reg", e, b ? rd2 : rd1);
    endtask
    // ------------------------------------------------------------
    // bit-bang host on the second link
    // ------------------------------------------------------------
    task automatic qw();
        repeat (16) @(posedge sys_clk);
    endtask
    task automatic bit_io(input logic b, output logic s);
        link2.sda_oe_n_host <= b;
        qw();
        link2.scl_oe_n_host <= 1'b1;
        qw();
        s = link2.sda;
        qw();
        link2.scl_oe_n_host <= 1'b0;
        qw();
    endtask
    task automatic bb_edge(input logic start);
        // start: sda falls under high scl; stop: sda low, scl up, sda up
        link2.sda_oe_n_host <= 1'b0;
        qw();
        link2.scl_oe_n_host <= ~start;
        qw();
        if (!start) begin
            link2.sda_oe_n_host <= 1'b1;
            qw();
        end
    endtask
    task automatic bb_byte(input logic [7:0] v, input logic ack_lvl);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(v[i], s);
        bit_io(1'b1, s);
        chk("ack", {7'h00, ack_lvl}, {7'h00, s});
    endtask
    task automatic bb_frame(input logic [7:0] a, input logic [7:0] i, input logic [7:0] c,
                            input logic [7:0] d0, input logic al, input logic dl);
        bb_edge(1'b1);
        bb_byte(a, al);
        bb_byte(i, al);
        bb_byte(c, al);
        bb_byte(d0, dl);
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_wrap();
        bb_frame(SMBIW_WR_ADDR, 8'hFF, 8'h02, 8'h11, 1'b0, 1'b0);
        bb_byte(8'h22, 1'b0);
        bb_byte(8'h33, 1'b1);
        bb_edge(1'b0);
        rchk(1'b1, 8'hFF, 8'h11);
        rchk(1'b1, 8'h00, 8'h22);
        rchk(1'b1, 8'h01, 8'h00);
        chk("wr_count2", 8'h02, n2);
    endtask
    task automatic t_foreign();
        bb_frame(SMBIW_RD_ADDR, 8'h40, 8'h01, 8'h44, 1'b1, 1'b1);
        bb_edge(1'b0);
        bb_frame(8'h52, 8'h40, 8'h01, 8'h44, 1'b1, 1'b1);
        bb_edge(1'b0);
        rchk(1'b1, 8'h40, 8'h00);
        chk("wr_count2", 8'h02, n2);
        chk("dev_busy2", 8'h00, {7'h00, db2});
    endtask
    task automatic t_zero();
        bb_frame(SMBIW_WR_ADDR, 8'h20, 8'h00, 8'h55, 1'b0, 1'b1);
        bb_edge(1'b0);
        rchk(1'b1, 8'h20, 8'h00);
        chk("wr_count2", 8'h02, n2);
    endtask
    task automatic t_host();
        int w;
        index <= 8'h7F;
        count <= 8'h01;
        data_in <= 8'hA5;
        req <= 1'b1;
        w = 0;
        do begin
            @(posedge sys_clk);
            w++;
        end while (hbusy !== 1'b1 && w < 8);
        req <= 1'b0;
        chk("host_busy", 8'h01, {7'h00, hbusy});
        w = 0;
        while (done !== 1'b1 && w < 20000) begin
            @(posedge sys_clk);
            w++;
        end
        chk("done", 8'h01, {7'h00, done});
        chk("nack_err", 8'h00, {7'h00, nack_err});
        chk("wr_index", 8'h7F, wi1);
        chk("wr_data", 8'hA5, wd1);
        chk("wr_count1", 8'h01, n1);
        chk("data_take", 8'h01, nt);
        chk("dev_busy_seen", 8'h01, {7'h00, saw_b});
        rchk(1'b0, 8'h7F, 8'hA5);
        rchk(1'b0, 8'h80, 8'h00);
        repeat (8) @(posedge sys_clk);
        chk("dev_busy", 8'h00, {7'h00, db1});
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        resetn = 1'b0;
        link2.scl_oe_n_host = 1'b1;
        link2.sda_oe_n_host = 1'b1;
        repeat (20) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        rchk(1'b0, 8'h00, SMBIW_REG_RESET);
        t_wrap();
        t_foreign();
        t_zero();
        t_host();
        print_verdict();
    end
endmodule
`default_nettype wire
